// ===== param_save.sv
// category save controller for the object dictionary save object
module param_save (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // object write from the fieldbus stack
   input wire logic wr_en_i,
   input wire logic [15:0] wr_index_i,
   input wire logic [7:0] wr_sub_i,
   input wire logic [31:0] wr_data_i,
   // object read of the save object
   input wire logic [7:0] rd_sub_i,
   output logic [31:0] rd_data_o,
   output logic rd_hit_o,
   // category lookup for any object index
   input wire logic [15:0] obj_index_i,
   output logic [5:0] obj_cat_o,
   // storage engine handshake
   output logic save_req_o,
   output logic [5:0] save_cats_o,
   input wire logic save_done_i,
   output logic busy_o
);
   param_save_pkg::save_state_e state_q, state_d;
   logic [param_save_pkg::NCAT-1:0] cats_q;
   logic [7:0] sub_q;
   logic [31:0] sub_val_q [param_save_pkg::NCAT+1];
   logic [param_save_pkg::NCAT-1:0] req_cats;
   logic sub_ok;
   logic [2:0] wr_slot, rd_slot;

   function automatic logic [2:0] slot_of(input logic [7:0] sub);
      unique case (sub)
         param_save_pkg::SUB_ALL: slot_of = 3'h0;
         param_save_pkg::SUB_COMM: slot_of = 3'h1;
         param_save_pkg::SUB_APP: slot_of = 3'h2;
         param_save_pkg::SUB_CUST: slot_of = 3'h3;
         param_save_pkg::SUB_DRIVE: slot_of = 3'h4;
         param_save_pkg::SUB_TUNE: slot_of = 3'h5;
         param_save_pkg::SUB_CAN: slot_of = 3'h6;
         default: slot_of = 3'h7;
      endcase
   endfunction

   always_comb begin
      wr_slot = slot_of(wr_sub_i);
      rd_slot = slot_of(rd_sub_i);
      sub_ok = (wr_slot != 3'h7);
      req_cats = param_save_pkg::CAT_NONE;
      unique case (wr_slot)
         3'h0: req_cats = param_save_pkg::CAT_ALL_MASK;
         3'h1: req_cats[param_save_pkg::CAT_COMM] = 1'b1;
         3'h2: req_cats[param_save_pkg::CAT_APP] = 1'b1;
         3'h3: req_cats[param_save_pkg::CAT_CUST] = 1'b1;
         3'h4: req_cats[param_save_pkg::CAT_DRIVE] = 1'b1;
         3'h5: req_cats[param_save_pkg::CAT_TUNE] = 1'b1;
         3'h6: req_cats[param_save_pkg::CAT_CAN] = 1'b1;
         default: req_cats = param_save_pkg::CAT_NONE;
      endcase
   end

   // whole categories only, no per-object path exists
   wire logic start = wr_en_i && (wr_index_i == param_save_pkg::SAVE_OBJ) && sub_ok
      && (wr_data_i == param_save_pkg::SAVE_CODE) && (state_q == param_save_pkg::ST_IDLE);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         param_save_pkg::ST_IDLE: if (start) state_d = param_save_pkg::ST_SAVE;
         param_save_pkg::ST_SAVE: if (save_done_i) state_d = param_save_pkg::ST_DONE;
         param_save_pkg::ST_DONE: state_d = param_save_pkg::ST_IDLE;
         default: state_d = param_save_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) state_q <= param_save_pkg::ST_IDLE;
      else state_q <= state_d;
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         cats_q <= param_save_pkg::CAT_NONE;
         sub_q <= 8'h00;
      end else if (start) begin
         cats_q <= req_cats;
         sub_q <= wr_sub_i;
      end
   end

   // subindex shows the written code while save_req_o is up, then 1 when finished
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i <= param_save_pkg::NCAT; i++) sub_val_q[i] <= 32'h0000_0000;
      end else if (start) begin
         sub_val_q[wr_slot] <= wr_data_i;
      end else if (state_q == param_save_pkg::ST_SAVE && save_done_i) begin
         sub_val_q[slot_of(sub_q)] <= param_save_pkg::DONE_VAL;
      end
   end

   always_comb begin
      rd_hit_o = (rd_slot != 3'h7);
      rd_data_o = rd_hit_o ? sub_val_q[rd_slot] : 32'h0000_0000;
   end

   // request stays up until storage answers
   assign save_req_o = (state_q == param_save_pkg::ST_SAVE);
   assign save_cats_o = cats_q;
   assign busy_o = (state_q != param_save_pkg::ST_IDLE);

   // category membership; reload at reset is done by the storage engine
   // explicit lists: state-dependent objects such as the statusword must never be savable
   always_comb begin
      obj_cat_o = param_save_pkg::CAT_NONE;
      case (obj_index_i) inside
         16'h1005,
         16'h1006,
         16'h1007,
         16'h100c,
         16'h100d,
         16'h1014,
         16'h1016,
         16'h1017,
         16'h1019,
         16'h1029,
         [16'h1400:16'h1407],
         [16'h1600:16'h1607],
         [16'h1800:16'h1807],
         [16'h1a00:16'h1a07],
         16'h1f80,
         16'h2102,
         16'h3502,
         16'h3602: obj_cat_o[param_save_pkg::CAT_COMM] = 1'b1;
         16'h2034,
         16'h2035,
         16'h2036,
         16'h2037,
         16'h2038,
         16'h203a,
         16'h203d,
         16'h203e,
         16'h203f,
         16'h2084,
         16'h2290,
         16'h2300,
         16'h2410,
         16'h2800,
         16'h3210,
         16'h3212,
         16'h321a,
         16'h321b,
         16'h321c,
         16'h321d,
         16'h321e,
         16'h3221,
         16'h3240,
         16'h3242,
         16'h3243,
         16'h3250,
         16'h3252,
         16'h3321,
         16'h3322,
         16'h3323,
         16'h3700,
         16'h3701,
         16'h4013,
         16'h4015,
         16'h6007,
         16'h6040,
         16'h6042,
         16'h6046,
         16'h6048,
         16'h6049,
         16'h604a,
         16'h604c,
         16'h605a,
         16'h605b,
         16'h605c,
         16'h605d,
         16'h605e,
         16'h6060,
         16'h6065,
         16'h6066,
         16'h6067,
         16'h6068,
         16'h606d,
         16'h606e,
         16'h606f,
         16'h6070,
         16'h6071,
         16'h6072,
         16'h607a,
         16'h607b,
         16'h607c,
         16'h607d,
         16'h607e,
         16'h607f,
         16'h6081,
         16'h6082,
         16'h6083,
         16'h6084,
         16'h6085,
         16'h6086,
         16'h6087,
         16'h6091,
         16'h6092,
         16'h6096,
         16'h6097,
         16'h6098,
         16'h6099,
         16'h609a,
         16'h60a2,
         16'h60a4,
         16'h60a8,
         16'h60a9,
         16'h60b0,
         16'h60b1,
         16'h60b2,
         16'h60c1,
         16'h60c2,
         16'h60c4,
         16'h60c5,
         16'h60c6,
         16'h60e8,
         16'h60e9,
         16'h60ed,
         16'h60ee,
         16'h60f2,
         16'h60f8,
         16'h60fe,
         16'h60ff: obj_cat_o[param_save_pkg::CAT_APP] = 1'b1;
         16'h2701: obj_cat_o[param_save_pkg::CAT_CUST] = 1'b1;
         16'h3202,
         16'h320d,
         16'h6073,
         16'h6080: obj_cat_o[param_save_pkg::CAT_DRIVE] = 1'b1;
         16'h2030,
         16'h2031,
         16'h203b,
         16'h3203,
         16'h3380,
         16'h33a0,
         16'h33b0,
         16'h4021,
         16'h6075,
         16'h608f,
         16'h6090,
         16'h60e6,
         16'h60eb: obj_cat_o[param_save_pkg::CAT_TUNE] = 1'b1;
         16'h2005,
         16'h2006,
         16'h2007,
         16'h2009: obj_cat_o[param_save_pkg::CAT_CAN] = 1'b1;
         default: obj_cat_o = param_save_pkg::CAT_NONE;
      endcase
   end
endmodule

// ===== param_save_pkg.sv
// constants for the category parameter save block
// Contract
// - one save subindex per category; each category subindex saves only its own category
// - writing 65766173h to a category subindex saves all objects of that category
// - after the save finishes the subindex reads back the value 1
// - all-categories subindex saves everything except the CANopen category
// - communication category includes TPDO mappings up to 1A07h and 1F80h
// - application category includes 2034h, 2035h, controlword and target values
// - customer category holds only the user storage area 2701h, uninterpreted
// - drive category includes 3202h, 320Dh, 6073h and 6080h
// - tuning category includes 2030h, 2031h, 203Bh, feedback objects, 6075h, resolutions
// - only whole categories are saved, never one object alone
// - saved values reload at power-on or reset and survive firmware update
package param_save_pkg;
   localparam logic [31:0] SAVE_CODE = 32'h6576_6173;
   localparam logic [31:0] DONE_VAL = 32'h0000_0001;
   localparam logic [15:0] SAVE_OBJ = 16'h1010;
   localparam logic [7:0] SUB_ALL = 8'h01;
   localparam logic [7:0] SUB_COMM = 8'h02;
   localparam logic [7:0] SUB_APP = 8'h03;
   localparam logic [7:0] SUB_CUST = 8'h04;
   localparam logic [7:0] SUB_DRIVE = 8'h05;
   localparam logic [7:0] SUB_TUNE = 8'h06;
   localparam logic [7:0] SUB_CAN = 8'h0a;
   localparam int NCAT = 6;
   // category bit positions
   localparam int CAT_COMM = 0;
   localparam int CAT_APP = 1;
   localparam int CAT_CUST = 2;
   localparam int CAT_DRIVE = 3;
   localparam int CAT_TUNE = 4;
   localparam int CAT_CAN = 5;
   localparam logic [NCAT-1:0] CAT_ALL_MASK = 6'h1f;
   localparam logic [NCAT-1:0] CAT_NONE = 6'h00;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAVE = 2'b01,
      ST_DONE = 2'b10
   } save_state_e;
endpackage

// ===== param_save_props.sv
// port checks for the category save controller
module param_save_props (
   input wire logic sys_clk_i, input wire logic reset_n_i, input wire logic wr_en_i,
   input wire logic [15:0] wr_index_i, input wire logic [7:0] wr_sub_i,
   input wire logic [31:0] wr_data_i, input wire logic save_req_o,
   input wire logic [5:0] save_cats_o, input wire logic save_done_i, input wire logic busy_o,
   input wire logic [7:0] rd_sub_i, input wire logic [31:0] rd_data_o, input wire logic rd_hit_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic go;
   logic [5:0] own;
   logic [7:0] sub_seen_q;
   // remembers which subindex the running save belongs to
   always_ff @(posedge sys_clk_i) begin
      if (go) sub_seen_q <= wr_sub_i;
   end
   assign go = wr_en_i && !busy_o && wr_index_i == 16'h1010 && wr_data_i == 32'h6576_6173
      && wr_sub_i inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0a};
   assign own = wr_sub_i == 8'h0a ? 6'h20 : 6'h01 << (wr_sub_i - 8'h02);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_finish; !save_req_o && busy_o ##1 !busy_o; endsequence
   sequence s_landed; save_req_o && save_done_i ##1 rd_sub_i == sub_seen_q; endsequence
   property p_take; go |=> save_req_o && busy_o; endproperty
   a_take: assert property (p_take) else $error("save not started");
   property p_hold; save_req_o && !save_done_i |=> save_req_o; endproperty
   a_hold: assert property (p_hold) else $error("save dropped early");
   property p_done; save_req_o && save_done_i |=> s_finish; endproperty
   a_done: assert property (p_done) else $error("bad save finish");
   property p_all; go && wr_sub_i == 8'h01 |=> save_cats_o == 6'h1f; endproperty
   a_all: assert property (p_all) else $error("wrong full save set");
   property p_own; go && wr_sub_i != 8'h01 |=> save_cats_o == $past(own); endproperty
   a_own: assert property (p_own) else $error("wrong category saved");
   property p_refuse; wr_en_i && !busy_o && !go |=> !save_req_o; endproperty
   a_refuse: assert property (p_refuse) else $error("bad write started save");
   property p_keep; save_req_o && !$rose(save_req_o) |-> $stable(save_cats_o); endproperty
   a_keep: assert property (p_keep) else $error("category set changed");
   property p_idle; !busy_o && !go |=> !busy_o; endproperty
   a_idle: assert property (p_idle) else $error("busy without valid request");
   property p_mark; s_landed |-> rd_data_o == 32'h0000_0001; endproperty
   a_mark: assert property (p_mark) else $error("finished save not marked");
   property p_hit;
      rd_hit_o == (rd_sub_i inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0a});
   endproperty
   a_hit: assert property (p_hit) else $error("wrong subindex decode");
endmodule
bind param_save param_save_props i_param_save_props (.sys_clk_i, .reset_n_i, .wr_en_i,
   .wr_index_i, .wr_sub_i, .wr_data_i, .save_req_o, .save_cats_o, .save_done_i, .busy_o,
   .rd_sub_i, .rd_data_o, .rd_hit_o);

// ===== store_model.sv
// storage engine stand-in: finishes a save lat_i plus one cycles after the request
module store_model (
   input wire logic clk_i, input wire logic reset_n_i, input wire logic req_i,
   input wire logic [3:0] lat_i, output logic done_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_q;
   always_ff @(posedge clk_i) begin
      cnt_q <= (!reset_n_i || !req_i || done_o) ? 4'h0 : cnt_q + 4'h1;
      done_o <= reset_n_i && req_i && !done_o && cnt_q == lat_i;
   end
endmodule

// ===== test_param_save.sv
// self-checking bench for the category save controller
module test_param_save;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_i = 1'b0, reset_n_i = 1'b0, wr_en_i = 1'b0, rd_hit_o, save_req_o, save_done_i;
   logic busy_o;
   logic [15:0] wr_index_i = 16'h0000, obj_index_i = 16'h0000;
   logic [7:0] wr_sub_i = 8'h00, rd_sub_i = 8'h00;
   logic [31:0] wr_data_i = 32'h0000_0000, rd_data_o;
   logic [31:0] exp_rd [16] = '{default: 32'h0000_0000};
   logic [5:0] obj_cat_o, save_cats_o;
   logic [3:0] lat = 4'h0;
   logic [7:0] subs [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0a, 8'h07, 8'h00};
   logic [15:0] idxs [9] = '{16'h1a07, 16'h2034, 16'h2701, 16'h3202, 16'h2031, 16'h2009, 16'h1000,
      16'h6041, 16'h1010};
   logic [5:0] cats [9] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h00, 6'h00, 6'h00};
   int fails = 0, checks_done = 0, cyc = 0;
   param_save i_param_save (.sys_clk_i, .reset_n_i, .wr_en_i, .wr_index_i, .wr_sub_i, .wr_data_i,
      .rd_sub_i, .rd_data_o, .rd_hit_o, .obj_index_i, .obj_cat_o, .save_req_o, .save_cats_o,
      .save_done_i, .busy_o);
   store_model i_store_model (.clk_i(sys_clk_i), .reset_n_i, .req_i(save_req_o), .lat_i(lat),
      .done_o(save_done_i));
   initial forever #20 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         close_out();
      end
   end
   function automatic logic [5:0] cats_of(input logic [7:0] s);
      // the full save leaves the bus category out
      if (s == 8'h01 || s == 8'h0a) return s == 8'h01 ? 6'h1f : 6'h20;
      return (s > 8'h01 && s < 8'h07) ? 6'h01 << (s - 8'h02) : 6'h00;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic put(input logic [15:0] idx, input logic [7:0] s, input logic [31:0] d);
      logic ok;
      ok = idx == 16'h1010 && cats_of(s) != 6'h00 && d == param_save_pkg::SAVE_CODE;
      @(posedge sys_clk_i);
      wr_en_i <= 1'b1;
      wr_index_i <= idx;
      wr_sub_i <= s;
      wr_data_i <= d;
      rd_sub_i <= s;
      lat <= 4'($urandom % 9);
      @(posedge sys_clk_i);
      wr_en_i <= 1'b0;
      #1;
      check(32'(save_req_o), 32'(ok));
      check(32'(busy_o), 32'(ok));
      check(rd_data_o, ok ? d : exp_rd[s[3:0]]);
      if (!ok) return;
      check(32'(save_cats_o), 32'(cats_of(s)));
      exp_rd[s[3:0]] = 32'h0000_0001;
      // a second request mid-save must be ignored
      @(posedge sys_clk_i);
      wr_en_i <= 1'b1;
      wr_sub_i <= s ^ 8'h08;
      @(posedge sys_clk_i);
      wr_en_i <= 1'b0;
      #1;
      for (int n = 0; n < 30 && busy_o !== 1'b0; n++) @(posedge sys_clk_i) #1;
      check(rd_data_o, 32'h0000_0001);
   endtask
   initial begin
      void'($urandom(58));
      repeat (12) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      put(16'h1011, 8'h02, param_save_pkg::SAVE_CODE);
      for (int i = 0; i < 40; i++) begin
         put(16'h1010, i < 9 ? subs[i] : subs[$urandom % 9],
            i < 9 || $urandom % 2 ? param_save_pkg::SAVE_CODE : $urandom);
      end
      foreach (subs[i]) begin
         @(posedge sys_clk_i);
         rd_sub_i <= subs[i];
         obj_index_i <= idxs[i];
         #1;
         check(rd_data_o, exp_rd[subs[i][3:0]]);
         check(32'(rd_hit_o), 32'(cats_of(subs[i]) != 6'h00));
         check(32'(obj_cat_o), 32'(cats[i]));
      end
      close_out();
   end
endmodule
